// File: bench/hpi_host.sv
// Host bus master model driving the host port pins
`timescale 1ns/1ps
module hpi_host
   import hpi_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic rdyN, // Ready, low when done
   input wire logic [7:0] adOut, // Shared bus as the host sees it
   input wire logic sdo, // Serial data as the host sees it
   output hpi_pins_s p // Host pin levels
);
   initial begin
      p = '0;
      p.csN = 1'b1;
      p.wrN = 1'b1;
      p.rdN = 1'b1;
   end

   // Codes 5 and 7 are serial; serial reads use the trailing edge phase
   task automatic xfer(input logic [2:0] s, input logic wr,
      input logic [8:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic ok);
      logic [15:0] f;
      logic mux;
      int n;
      q = 8'h00;
      ok = 1'b1;
      n = 0;
      mux = s[1] & ~s[0];
      f = {~wr, a[6:0], d};
      @(negedge clk);
      if (s[2] && s[0]) begin
         p.cpol = s[1];
         p.cpha = ~wr;
         p.sclk = s[1];
         // Phase and polarity settle before the frame opens
         repeat (4) @(negedge clk);
         p.csN = 1'b0;
         for (int i = 0; i < 16; i++) begin
            n = s[1] ? 15 - i : {~i[3], i[2:0]};
            if (!p.cpha) p.sdi = f[n];
            #32 p.sclk = ~p.cpol;
            if (p.cpha) p.sdi = f[n];
            else if (i > 7) q[s[1] ? 7 - i[2:0] : i[2:0]] = sdo;
            #32 p.sclk = p.cpol;
            if (p.cpha && i > 7) q[s[1] ? 7 - i[2:0] : i[2:0]] = sdo;
         end
         // Link clock stands still between frames
         #32 p.csN = 1'b1;
         p.sdi = ~p.sdi;
      end else begin
         p.csN = 1'b0;
         p.ale = 1'b1;
         p.addr = mux ? {a[8], 8'h00} : a;
         p.adIn = mux ? a[7:0] : d;
         if (s[2]) p.wrN = ~wr;
         repeat (4) @(negedge clk);
         p.ale = ~mux;
         // In multiplexed modes drop the latch a cycle before the bus turns to data; otherwise ALE stays high
         @(negedge clk);
         p.adIn = wr ? d : ~p.adIn;
         if (wr && !s[2]) p.wrN = 1'b0;
         else p.rdN = 1'b0;
         if (wr) begin
            repeat (6) @(negedge clk);
            ok = (rdyN === 1'b0);
         end else begin
            // Ready and data are looked at off the edge that launches them
            while (rdyN !== 1'b0 && n < 20) begin
               @(negedge clk);
               n++;
            end
            ok = (rdyN === 1'b0);
            q = adOut;
            @(negedge clk);
         end
         // Strobe rises first so the write commits while still selected
         p.rdN = 1'b1;
         if (!s[2]) p.wrN = 1'b1;
         repeat (2) @(negedge clk);
         p.wrN = 1'b1;
         p.csN = 1'b1;
         p.ale = 1'b0;
         p.adIn = ~p.adIn;
      end
      repeat (6) @(negedge clk);
   endtask
endmodule

// File: bench/tb_top.sv
// Self-checking testbench for the host processor port
`timescale 1ns/1ps
module tb_top;
   import hpi_pkg::*;
   typedef struct packed {
      logic [2:0] sel;
      logic prim;
      logic rate;
      logic [8:0] addr;
      logic [7:0] data;
   } hpi_row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] sel = 3'h3;
   logic prim = 1'b0;
   logic rate = 1'b0;
   logic floatN = 1'b1;
   logic tstRstN = 1'b1;
   logic wdTrip = 1'b0;
   logic refFail = 1'b0;
   logic irqEvent = 1'b0;
   hpi_pins_s hp;
   hpi_pins_s pins;
   logic [7:0] adOut;
   logic [7:0] q;
   logic adOeN, rdyN, rdyOeN, sdo, sdoOeN, irqOut, irqOeN;
   logic refFailPin, refFailOeN;
   int fails = 0;
   int nCompared = 0;
   hpi_row_s r;
   hpi_row_s rows [6] = '{
      '{3'h2, 1'b1, 1'b0, 9'h1C3, 8'hA5},
      '{3'h3, 1'b0, 1'b1, 9'h155, 8'h3C},
      '{3'h4, 1'b1, 1'b1, 9'h0AA, 8'h96},
      '{3'h5, 1'b0, 1'b0, 9'h041, 8'hC3},
      '{3'h6, 1'b0, 1'b1, 9'h17E, 8'h69},
      '{3'h7, 1'b1, 1'b0, 9'h07F, 8'h81}};

   initial begin
      forever #4 clk = ~clk;
   end

   always_comb begin
      pins = hp;
      if (!adOeN) pins.adIn = adOut;
   end

   // A floated line reads as the inverse of what the device would show
   hpi_host i_hpi_host (.clk(clk), .rdyN(rdyN),
      .adOut(adOut ^ {8{adOeN}}), .sdo(sdo ^ sdoOeN), .p(hp));

   hpi_port i_hpi_port (.clk(clk), .rst(rst), .hostPortSelect(sel),
      .primarySecondarySelect(prim), .rateFamilySelect(rate),
      .outputFloatN(floatN), .testPortResetN(tstRstN),
      .oscWatchdogTrip(wdTrip), .referenceFail(refFail),
      .irqEvent(irqEvent), .pins(pins), .adOut(adOut), .adOeN(adOeN),
      .rdyN(rdyN), .rdyOeN(rdyOeN), .sdo(sdo), .sdoOeN(sdoOeN),
      .irqOut(irqOut), .irqOeN(irqOeN), .refFailPin(refFailPin),
      .refFailOeN(refFailOeN));

   task automatic finishTest();
      $display("compared %0d mismatches %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cmp(input logic [7:0] g, e, input string m);
      nCompared++;
      if (g !== e) begin
         fails++;
         $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic cmpb(input logic g, e, input string m);
      nCompared++;
      if (g !== e) begin
         fails++;
         $display("FAIL %0t %s got %b", $time, m, g);
      end
   endtask

   task automatic acc(input logic wr, input logic [8:0] a,
      input logic [7:0] d);
      logic ok;
      i_hpi_host.xfer(sel, wr, a, d, q, ok);
      if (!ok) begin
         fails++;
         $display("FAIL %0t no ready", $time);
         finishTest();
      end
   endtask

   task automatic rdc(input logic [8:0] a, input logic [7:0] e,
      input string m);
      acc(1'b0, a, 8'h00);
      cmp(q, e, m);
   endtask

   task automatic doReset(input hpi_row_s x);
      @(negedge clk);
      rst = 1'b1;
      sel = x.sel;
      prim = x.prim;
      rate = x.rate;
      repeat (2) @(negedge clk);
      cmpb(rdyN, 1'b1, "ready in reset");
      cmpb(adOeN & sdoOeN & rdyOeN, 1'b1, "float in reset");
      rst = 1'b0;
      repeat (5) @(negedge clk);
   endtask

   initial begin
      foreach (rows[k]) begin
         r = rows[k];
         doReset(r);
         rdc(HPI_ADDR_PORTCFG, {5'h00, r.sel}, "select");
         rdc(HPI_ADDR_MODE3, {6'h00, r.rate, r.prim}, "mode3");
         rdc(HPI_ADDR_MODE6, {6'h00, r.rate, r.rate}, "mode6");
         rdc(HPI_ADDR_AUX1, {7'h00, r.rate}, "aux1");
         acc(1'b1, r.addr, r.data);
         rdc(r.addr, r.data, "ram");
         $display("done mode %h", r.sel);
      end
      doReset('{3'h3, 1'b1, 1'b0, 9'h000, 8'h00});
      cmpb(adOeN, 1'b1, "bus idle");
      cmpb(sdoOeN, 1'b1, "serial idle");
      acc(1'b1, HPI_ADDR_MODE10, 8'h00);
      refFail = 1'b1;
      repeat (4) @(negedge clk);
      cmpb(refFailPin, 1'b0, "fail pin off");
      cmpb(refFailOeN, 1'b0, "fail pin driven");
      acc(1'b1, HPI_ADDR_MODE10, 8'h01);
      cmpb(refFailPin, 1'b1, "fail pin on");
      refFail = 1'b0;
      repeat (4) @(negedge clk);
      cmpb(refFailPin, 1'b0, "fail pin clear");
      acc(1'b1, HPI_ADDR_IRQCFG, 8'h0C);
      cmpb(irqOut, 1'b1, "irq as output");
      cmpb(irqOeN, 1'b0, "irq push-pull");
      acc(1'b1, HPI_ADDR_IRQCFG, 8'h03);
      cmpb(irqOeN, 1'b1, "irq open drain idle");
      irqEvent = 1'b1;
      repeat (2) @(negedge clk);
      cmpb(irqOut, 1'b1, "irq active high");
      cmpb(irqOeN, 1'b0, "irq open drain drives");
      irqEvent = 1'b0;
      $display("done pins");
      wdTrip = 1'b1;
      rdc(HPI_ADDR_PORTCFG, HPI_READ_FAIL, "watchdog cfg");
      rdc(9'h155, HPI_READ_FAIL, "watchdog ram");
      wdTrip = 1'b0;
      rdc(HPI_ADDR_PORTCFG, 8'h03, "after watchdog");
      $display("done watchdog");
      floatN = 1'b0;
      repeat (4) @(negedge clk);
      cmpb(refFailOeN, 1'b0, "no float");
      tstRstN = 1'b0;
      repeat (4) @(negedge clk);
      cmpb(adOeN & rdyOeN & sdoOeN & irqOeN & refFailOeN, 1'b1,
         "float");
      floatN = 1'b1;
      tstRstN = 1'b1;
      $display("done float");
      finishTest();
   end
endmodule

// File: rtl/hpi_pkg.sv
// Package for the host processor interface: constants and carriers
package hpi_pkg;
   localparam int HPI_AW = 9;
   localparam int HPI_DW = 8;
   localparam int HPI_REGS = 512;
   localparam int HPI_SPI_BITS = 16;
   localparam logic [3:0] HPI_SPI_CNT_W = 4'h0;
   localparam logic [2:0] HPI_SEL_RESET = 3'h0;
   localparam logic [7:0] HPI_READ_FAIL = 8'h00;
   // Register indices of the mode bits this port owns
   localparam logic [8:0] HPI_ADDR_PORTCFG = 9'h000;
   localparam logic [8:0] HPI_ADDR_MODE3 = 9'h001;
   localparam logic [8:0] HPI_ADDR_MODE6 = 9'h002;
   localparam logic [8:0] HPI_ADDR_AUX1 = 9'h003;
   localparam logic [8:0] HPI_ADDR_MODE10 = 9'h004;
   localparam logic [8:0] HPI_ADDR_IRQCFG = 9'h005;
   localparam int HPI_BIT_PRIMARY = 0;
   localparam int HPI_BIT_RATEFAM = 1;
   localparam int HPI_BIT_DIG1 = 0;
   localparam int HPI_BIT_DIG2 = 1;
   localparam int HPI_BIT_FIXRATE = 0;
   localparam int HPI_BIT_REFPIN = 0;
   localparam int HPI_BIT_IRQPOL = 0;
   localparam int HPI_BIT_IRQOD = 1;
   localparam int HPI_BIT_IRQGP = 2;
   localparam int HPI_BIT_IRQGPV = 3;

   typedef enum logic [2:0] {
      HPI_SEL_STB_MUX = 3'h2,
      HPI_SEL_STB_SEP = 3'h3,
      HPI_SEL_DIR_SEP = 3'h4,
      HPI_SEL_SPI_LSB = 3'h5,
      HPI_SEL_DIR_MUX = 3'h6,
      HPI_SEL_SPI_MSB = 3'h7
   } hpi_sel_e;

   typedef struct packed {
      logic csN;
      logic ale;
      logic wrN;
      logic rdN;
      logic [8:0] addr;
      logic [7:0] adIn;
      logic sclk;
      logic sdi;
      logic cpha;
      logic cpol;
   } hpi_pins_s;
endpackage

// File: rtl/hpi_port.sv
// Host processor port: parallel and serial register access
`timescale 1ns/1ps
module hpi_port
   import hpi_pkg::*;
(
   input wire logic clk, // Local oscillator clock
   input wire logic rst, // Async reset, active high
   input wire logic [2:0] hostPortSelect, // Interface select straps
   input wire logic primarySecondarySelect, // Primary strap
   input wire logic rateFamilySelect, // Rate family strap
   input wire logic outputFloatN, // Float all outputs, low together with testPortResetN low
   input wire logic testPortResetN, // Test reset, low enables float
   input wire logic oscWatchdogTrip, // Oscillator watchdog tripped
   input wire logic referenceFail, // Reference fail status
   input wire logic irqEvent, // Internal interrupt request
   input wire hpi_pins_s pins, // Host bus pins
   output logic [7:0] adOut, // Shared bus output data
   output logic adOeN, // Shared bus enable, low drives
   output logic rdyN, // Ready, low when done
   output logic rdyOeN, // Ready enable, low drives
   output logic sdo, // Serial data out
   output logic sdoOeN, // Serial enable, low drives
   output logic irqOut, // Interrupt pin value
   output logic irqOeN, // Interrupt enable, low drives
   output logic refFailPin, // Reference fail pin
   output logic refFailOeN // Reference fail enable, low drives
);
   logic csS, aleS, wrS, rdS, sclkS, sdiS, cphaS, cpolS, flN, trN;
   logic [8:0] addrS;
   logic [7:0] adS;
   localparam int NS = 27;
   logic [NS-1:0] syncIn, syncOut;
   assign syncIn = {pins.csN, pins.ale, pins.wrN, pins.rdN, pins.addr,
      pins.adIn, pins.sclk, pins.sdi, pins.cpha, pins.cpol, outputFloatN,
      testPortResetN};
   assign {csS, aleS, wrS, rdS, addrS, adS, sclkS, sdiS, cphaS, cpolS,
      flN, trN} = syncOut;
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         hpi_sync #(.RESET_VAL(1'b1)) u_sync (
            .clk(clk),
            .rst(rst),
            .d(syncIn[gi]),
            .q(syncOut[gi])
         );
      end
   endgenerate

   logic [7:0] regMem [HPI_REGS];

   typedef struct packed {
      logic strapped;
      logic [2:0] sel;
      logic [8:0] addr;
      logic csPrev;
      logic rdPrev;
      logic wrPrev;
      logic sclkPrev;
      logic [7:0] adOut;
      logic adOeN;
      logic rdyN;
      logic [4:0] bitCnt;
      logic [15:0] shIn;
      logic [7:0] shOut;
      logic sdo;
      logic sdoOeN;
      logic primary;
      logic rateFam;
      logic dig1;
      logic dig2;
      logic fixRate;
      logic refPinEn;
      logic [3:0] irqCfg;
      logic irqOut;
      logic irqOeN;
      logic refFail;
      logic refOeN;
      logic wrEn;
      logic [8:0] wrAddr;
      logic [7:0] wrData;
   } hpi_state_s;

   hpi_state_s s_q, s_d;
   logic isSpi, isDir, isMux, floatAll, rdStb, wrStb, spiEdge, lead;
   logic [7:0] rdData, rdLive;
   logic [8:0] curAddr;
   logic [7:0] spiByte, spiHead;
   logic irqAct;

   function automatic logic [7:0] bitrev(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         bitrev[i] = v[7 - i];
      end
   endfunction

   always_comb begin
      isSpi = s_q.sel == HPI_SEL_SPI_LSB
         || s_q.sel == HPI_SEL_SPI_MSB;
      isDir = s_q.sel == HPI_SEL_DIR_SEP
         || s_q.sel == HPI_SEL_DIR_MUX;
      isMux = s_q.sel == HPI_SEL_STB_MUX
         || s_q.sel == HPI_SEL_DIR_MUX;
      floatAll = !flN && !trN;
      // Serial head byte in MSB-first order: so far, and once complete
      spiByte = s_q.sel == HPI_SEL_SPI_LSB
         ? bitrev({s_q.shIn[6:0], sdiS}) : {s_q.shIn[6:0], sdiS};
      spiHead = s_q.sel == HPI_SEL_SPI_LSB
         ? bitrev(s_q.shIn[14:7]) : s_q.shIn[14:7];
      if (isSpi) begin
         // Read flag takes bit 7, so serial access reaches 7 address bits
         curAddr = {2'b00, spiByte[6:0]};
      end else begin
         // Latched address, transparent while ALE is high
         curAddr = aleS ? (isMux ? {addrS[8], adS} : addrS)
            : s_q.addr;
      end
      unique case (curAddr)
         HPI_ADDR_PORTCFG: rdLive = {5'h00, s_q.sel};
         HPI_ADDR_MODE3: rdLive = {6'h00, s_q.rateFam, s_q.primary};
         HPI_ADDR_MODE6: rdLive = {6'h00, s_q.dig2, s_q.dig1};
         HPI_ADDR_AUX1: rdLive = {7'h00, s_q.fixRate};
         HPI_ADDR_MODE10: rdLive = {7'h00, s_q.refPinEn};
         HPI_ADDR_IRQCFG: rdLive = {4'h0, s_q.irqCfg};
         default: rdLive = regMem[curAddr];
      endcase
      rdData = oscWatchdogTrip ? HPI_READ_FAIL : rdLive;
      // Direction mode: RW high reads under DS low; strobe mode: RD/WR
      rdStb = !csS && (isDir ? (wrS && !rdS) : !rdS);
      wrStb = !csS && (isDir ? !wrS : !wrS);
      // Leading edge is rising for polarity 0, falling for 1
      lead = (sclkS != s_q.sclkPrev) && (sclkS != cpolS);
      spiEdge = (sclkS != s_q.sclkPrev) && !csS;

      s_d = s_q;
      s_d.wrEn = 1'b0;
      if (!s_q.strapped) begin
         s_d.strapped = 1'b1;
         s_d.sel = hostPortSelect;
         s_d.primary = primarySecondarySelect;
         s_d.rateFam = rateFamilySelect;
         s_d.dig1 = rateFamilySelect;
         s_d.dig2 = rateFamilySelect;
         s_d.fixRate = rateFamilySelect;
      end
      s_d.csPrev = csS;
      s_d.rdPrev = rdS;
      s_d.wrPrev = wrS;
      s_d.sclkPrev = sclkS;
      if (aleS) begin
         s_d.addr = isMux ? {addrS[8], adS} : addrS;
      end
      s_d.adOeN = 1'b1;
      s_d.rdyN = 1'b1;
      if (!isSpi && s_q.strapped) begin
         if (rdStb) begin
            s_d.adOut = rdData;
            s_d.adOeN = 1'b0;
            s_d.rdyN = 1'b0;
         end
         if (isDir ? (!csS && !wrS && rdS && !s_q.rdPrev)
               : (!csS && wrS && !s_q.wrPrev)) begin
            s_d.wrEn = 1'b1;
            s_d.wrAddr = s_q.addr;
            s_d.wrData = adS;
         end
         if (wrStb && (isDir ? !rdS : 1'b1)) begin
            s_d.rdyN = 1'b0;
         end
      end
      s_d.sdoOeN = !(isSpi && !csS);
      if (isSpi) begin
         if (csS) begin
            s_d.bitCnt = 5'h00;
         end else if (spiEdge && (lead ^ cphaS)) begin
            // Sample edge, first byte address, second data
            s_d.shIn = {s_q.shIn[14:0], sdiS};
            s_d.bitCnt = s_q.bitCnt + 5'h01;
            if (s_q.bitCnt == 5'h07) begin
               s_d.shOut = s_q.sel == HPI_SEL_SPI_LSB ? bitrev(rdData)
                  : rdData;
            end
            if (s_q.bitCnt == 5'h0F) begin
               // Head byte bit 7 is the read flag, the rest the address
               s_d.wrEn = !spiHead[7];
               s_d.wrAddr = {2'b00, spiHead[6:0]};
               s_d.wrData = s_q.sel == HPI_SEL_SPI_LSB
                  ? bitrev({s_q.shIn[6:0], sdiS}) : {s_q.shIn[6:0], sdiS};
            end
         end else if (spiEdge) begin
            s_d.sdo = s_q.shOut[7];
            s_d.shOut = {s_q.shOut[6:0], 1'b0};
         end
      end
      if (s_q.wrEn) begin
         unique case (s_q.wrAddr)
            HPI_ADDR_MODE3: begin
               s_d.primary = s_q.wrData[HPI_BIT_PRIMARY];
               s_d.rateFam = s_q.wrData[HPI_BIT_RATEFAM];
            end
            HPI_ADDR_MODE6: begin
               s_d.dig1 = s_q.wrData[HPI_BIT_DIG1];
               s_d.dig2 = s_q.wrData[HPI_BIT_DIG2];
            end
            HPI_ADDR_AUX1: s_d.fixRate = s_q.wrData[HPI_BIT_FIXRATE];
            HPI_ADDR_MODE10: s_d.refPinEn = s_q.wrData[HPI_BIT_REFPIN];
            HPI_ADDR_IRQCFG: s_d.irqCfg = s_q.wrData[3:0];
            default: ;
         endcase
      end
      s_d.refFail = s_q.refPinEn ? referenceFail : 1'b0;
      s_d.refOeN = 1'b0;
      // Open drain drives only the asserted level
      irqAct = s_q.irqCfg[HPI_BIT_IRQGP] ? s_q.irqCfg[HPI_BIT_IRQGPV]
         : ((irqEvent || oscWatchdogTrip) ~^ s_q.irqCfg[HPI_BIT_IRQPOL]);
      s_d.irqOut = irqAct;
      s_d.irqOeN = s_q.irqCfg[HPI_BIT_IRQOD]
         ? (irqAct != s_q.irqCfg[HPI_BIT_IRQPOL]) : 1'b0;
      if (floatAll) begin
         s_d.adOeN = 1'b1;
         s_d.sdoOeN = 1'b1;
         s_d.irqOeN = 1'b1;
         s_d.refOeN = 1'b1;
      end
   end

   // Async reset loads constants only; straps are caught after release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.sel <= HPI_SEL_RESET;
         s_q.csPrev <= 1'b1;
         s_q.rdPrev <= 1'b1;
         s_q.wrPrev <= 1'b1;
         s_q.sclkPrev <= 1'b1;
         s_q.adOeN <= 1'b1;
         s_q.rdyN <= 1'b1;
         s_q.sdoOeN <= 1'b1;
         s_q.irqOeN <= 1'b1;
         s_q.refOeN <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Plain storage has no reset; the mode bits above are held in s_q
   always_ff @(posedge clk) begin
      if (s_q.wrEn) begin
         regMem[s_q.wrAddr] <= s_q.wrData;
      end
   end

   assign adOut = s_q.adOut;
   assign adOeN = s_q.adOeN;
   assign rdyN = s_q.rdyN;
   assign rdyOeN = s_q.refOeN;
   assign sdo = s_q.sdo;
   assign sdoOeN = s_q.sdoOeN;
   assign irqOut = s_q.irqOut;
   assign irqOeN = s_q.irqOeN;
   assign refFailPin = s_q.refFail;
   assign refFailOeN = s_q.refOeN;

   property p_wdread;
      @(posedge clk) disable iff (rst)
         oscWatchdogTrip && rdStb && !isSpi && s_q.strapped
         |=> s_q.adOut == HPI_READ_FAIL;
   endproperty
   a_wdread: assert property (p_wdread)
      else $error("read not zero");
   property p_refpin;
      @(posedge clk) disable iff (rst)
         !s_q.refPinEn ##1 !s_q.refPinEn |-> !refFailPin;
   endproperty
   a_refpin: assert property (p_refpin)
      else $error("fail pin high");
   property p_float;
      @(posedge clk) disable iff (rst)
         floatAll |=> adOeN && sdoOeN && irqOeN && refFailOeN;
   endproperty
   a_float: assert property (p_float)
      else $error("pins not floated");
   property p_adonly;
      @(posedge clk) disable iff (rst)
         !adOeN |-> $past(rdStb) && $past(!isSpi);
   endproperty
   a_adonly: assert property (p_adonly) else $error("bus driven");
   property p_sdo;
      @(posedge clk) disable iff (rst) $past(csS) |-> sdoOeN;
   endproperty
   a_sdo: assert property (p_sdo) else $error("sdo driven");
   property p_rdy;
      @(posedge clk) disable iff (rst)
         !adOeN |-> !rdyN;
   endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_strap;
      @(posedge clk) disable iff (rst)
         $rose(s_q.strapped) |-> s_q.sel == $past(hostPortSelect);
   endproperty
   a_strap: assert property (p_strap) else $error("strap lost");
   property p_prim;
      @(posedge clk) disable iff (rst)
         $rose(s_q.strapped) |-> s_q.primary == $past(primarySecondarySelect)
            && s_q.dig1 == $past(rateFamilySelect);
   endproperty
   a_prim: assert property (p_prim) else $error("mode strap lost");
endmodule

// File: rtl/hpi_sync.sv
// Two-flop synchroniser for one pin input
`timescale 1ns/1ps
module hpi_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk, // Core clock
   input wire logic rst, // Async reset
   input wire logic d, // Asynchronous input
   output logic q // Synchronised level
);
   logic meta_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
